// file: verilog/fid_pkg.sv
// Constants, opcode fields and decoded-control types for the 14-bit instruction decoder
package fid_pkg;

  // ********************************
  // Word layout and timing
  // ********************************
  localparam int FID_WORD_W = 14;
  localparam int FID_ADDR_W = 7;
  localparam int FID_BIT_W = 3;
  localparam int FID_LIT_W = 11;
  localparam int FID_PHASES = 4;
  localparam int FID_PHASE_W = 2;
  localparam logic [FID_PHASE_W-1:0] FID_PHASE_LAST = 2'h3;
  localparam logic [FID_PHASE_W-1:0] FID_PHASE_FIRST = 2'h0;

  // ********************************
  // Group prefixes (bits 13:12)
  // ********************************
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;

  // ********************************
  // Byte-oriented nibbles (bits 11:8)
  // ********************************
  localparam logic [3:0] NIB_MISC = 4'h0;
  localparam logic [3:0] NIB_CLEAR = 4'h1;
  localparam logic [3:0] NIB_SUB_REG = 4'h2;
  localparam logic [3:0] NIB_DEC = 4'h3;
  localparam logic [3:0] NIB_OR_REG = 4'h4;
  localparam logic [3:0] NIB_AND_REG = 4'h5;
  localparam logic [3:0] NIB_XOR_REG = 4'h6;
  localparam logic [3:0] NIB_ADD_REG = 4'h7;
  localparam logic [3:0] NIB_MOVE_REG = 4'h8;
  localparam logic [3:0] NIB_COMPL = 4'h9;
  localparam logic [3:0] NIB_INC = 4'ha;
  localparam logic [3:0] NIB_DEC_SKIP = 4'hb;
  localparam logic [3:0] NIB_ROT_RIGHT = 4'hc;
  localparam logic [3:0] NIB_ROT_LEFT = 4'hd;
  localparam logic [3:0] NIB_SWAP = 4'he;
  localparam logic [3:0] NIB_INC_SKIP = 4'hf;

  // ********************************
  // Fixed control words and literal nibbles
  // ********************************
  localparam logic [7:0] LOW_STANDBY = 8'h63;
  localparam logic [7:0] LOW_CLR_WDOG = 8'h64;
  localparam logic [7:0] LOW_RETURN = 8'h08;
  localparam logic [7:0] LOW_RETURN_INT = 8'h09;
  localparam logic [7:0] LOW_CLEAR_ACC = 8'h03;
  localparam logic [3:0] NIB_OR_LIT = 4'h8;
  localparam logic [3:0] NIB_AND_LIT = 4'h9;
  localparam logic [3:0] NIB_XOR_LIT = 4'ha;

  // ********************************
  // File addresses needing special handling
  // ********************************
  localparam logic [FID_ADDR_W-1:0] FID_TIMER_ADDR = 7'h01;
  localparam logic [FID_ADDR_W-1:0] FID_PORT_LO_ADDR = 7'h05;
  localparam logic [FID_ADDR_W-1:0] FID_PORT_HI_ADDR = 7'h06;

  typedef enum logic [5:0] {
    OP_NOP, OP_MOVE_ACC_REG, OP_CLEAR_REG, OP_CLEAR_ACC, OP_SUB_ACC_FROM_REG, OP_DEC_REG,
    OP_OR_REG_ACC, OP_AND_REG_ACC, OP_XOR_REG_ACC, OP_ADD_REG_ACC, OP_MOVE_REG, OP_COMPL_REG,
    OP_INC_REG, OP_DEC_SKIP_ZERO, OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY, OP_SWAP_NIBBLES,
    OP_INC_SKIP_ZERO, OP_CLEAR_BIT, OP_SET_BIT, OP_SKIP_BIT_CLEAR, OP_SKIP_BIT_SET,
    OP_MOVE_LIT, OP_RETURN_LOAD_LIT, OP_OR_LIT_ACC, OP_AND_LIT_ACC, OP_XOR_LIT_ACC,
    OP_SUB_ACC_FROM_LIT, OP_ADD_LIT_ACC, OP_CALL, OP_DIRECT_JUMP, OP_RETURN, OP_RETURN_INT,
    OP_STANDBY, OP_CLEAR_WATCHDOG, OP_UNDEF
  } fid_op_t;

  // Decoded control word handed to the datapath
  typedef struct packed {
    fid_op_t op;
    logic upd_carry;
    logic upd_digit_carry;
    logic upd_zero;
    logic upd_wdog_flags;
    logic dest_file;
    logic [FID_ADDR_W-1:0] file_addr;
    logic [FID_BIT_W-1:0] bit_idx;
    logic [FID_LIT_W-1:0] literal;
    logic pc_change;
    logic cond_skip;
    logic from_pins;
    logic clr_prescaler;
  } fid_ctrl_t;

  localparam fid_ctrl_t FID_CTRL_NOP = '{op: OP_NOP, default: '0};

endpackage

// file: verilog/fid_phase_gen.sv
// Instruction-cycle phase generator: four oscillator periods per cycle
`timescale 1ns/100ps
`default_nettype none
module fid_phase_gen
  import fid_pkg::*;
#(
  parameter int PHASES = FID_PHASES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Phase outputs
  output logic [FID_PHASE_W-1:0] phase_out,
  output logic cycle_start_out,
  output logic cycle_end_out
);

  logic [FID_PHASE_W-1:0] phase_q;
  localparam logic [FID_PHASE_W-1:0] LAST = FID_PHASE_W'(PHASES - 1);

  // Free-running phase count, wraps after the last phase
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      phase_q <= '0;
    else if (phase_q == LAST)
      phase_q <= '0;
    else
      phase_q <= phase_q + 2'h1;
  end

  assign phase_out = phase_q;
  assign cycle_start_out = (phase_q == FID_PHASE_FIRST);
  assign cycle_end_out = (phase_q == LAST);

endmodule
`default_nettype wire

// file: verilog/fid_decoder.sv
// Top module: decodes 14-bit instruction words into datapath control, with skip and flush sequencing
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Register OR, XOR, AND with accumulator change only the zero flag.
// - Register add, register subtract and literal subtract change carry, digit carry, zero.
// - Rotates go through carry and change only the carry flag.
// - Decrement-and-skip skips when result is zero, costing two cycles, no flags.
// - Increment-and-skip skips when result is zero, costing two cycles, no flags.
// - Literal OR, AND, XOR use an 8-bit literal and change only zero.
// - Return-with-literal loads the literal into accumulator and takes two cycles.
// - Bit tests skip on clear or set bit; two cycles when skipping.
// - Standby word updates the watchdog status flags and takes one cycle.
// - Read-modify-write of an I/O port reads pin levels, not the latch.
// - Writing the timer register clears the prescaler when assigned to it.
// - Branches and true tests take two cycles, the second a no-operation.
// - Call and jump carry an 11-bit target and take two cycles.
// - Destination bit zero writes accumulator, one writes the file register.
// - An instruction cycle lasts exactly four oscillator periods.
// - The file address field is seven bits, 0x00 to 0x7F.
module fid_decoder
  import fid_pkg::*;
#(
  parameter logic [FID_ADDR_W-1:0] TIMER_ADDR = FID_TIMER_ADDR,
  parameter logic [FID_ADDR_W-1:0] PORT_LO_ADDR = FID_PORT_LO_ADDR,
  parameter logic [FID_ADDR_W-1:0] PORT_HI_ADDR = FID_PORT_HI_ADDR
)
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // Program memory word and datapath feedback
  input wire logic [FID_WORD_W-1:0] INSTR_IN,
  input wire logic RESULT_ZERO_IN,
  input wire logic TEST_BIT_IN,
  input wire logic PRESCALE_TO_TIMER_IN,
  // Decoded control and sequencing
  output fid_ctrl_t CTRL_OUT,
  output logic [FID_PHASE_W-1:0] PHASE_OUT,
  output logic CYCLE_END_OUT,
  output logic FLUSH_OUT
);
  import fid_pkg::*;

  // ********************************
  // Types and signals
  // ********************************
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } fid_state_t;

  fid_state_t state_q;
  fid_ctrl_t ctrl_q;
  logic cycle_end;
  logic need_flush;

  // ********************************
  // Phase generator
  // ********************************
  fid_phase_gen #(
    .PHASES(FID_PHASES)
  ) u_phase (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .phase_out(PHASE_OUT),
    .cycle_start_out(),
    .cycle_end_out(cycle_end)
  );

  // ********************************
  // Decode function
  // ********************************
  function automatic fid_ctrl_t decode(input logic [FID_WORD_W-1:0] w, input logic psc_timer);
    fid_ctrl_t c;
    logic [3:0] nib;
    logic is_port;
    c = FID_CTRL_NOP;
    nib = w[11:8];
    c.file_addr = w[FID_ADDR_W-1:0]; // 7-bit field in every file operation
    c.bit_idx = w[9:7];
    c.literal = w[FID_LIT_W-1:0];
    c.dest_file = w[7]; // Zero selects accumulator, one selects the file
    c.op = OP_UNDEF;
    case (w[13:12])
      GRP_BYTE:
      begin
        case (nib)
          NIB_MISC:
          begin
            if (w[7])
              c.op = OP_MOVE_ACC_REG;
            else if (w[7:0] == LOW_STANDBY)
              c.op = OP_STANDBY;
            else if (w[7:0] == LOW_CLR_WDOG)
              c.op = OP_CLEAR_WATCHDOG;
            else if (w[7:0] == LOW_RETURN)
              c.op = OP_RETURN;
            else if (w[7:0] == LOW_RETURN_INT)
              c.op = OP_RETURN_INT;
            else if (w[6:5] == 2'h0 && w[3:0] == 4'h0 && w[4] == 1'b0)
              c.op = OP_NOP;
            else
              c.op = OP_UNDEF;
          end
          NIB_CLEAR: c.op = w[7] ? OP_CLEAR_REG : OP_CLEAR_ACC;
          NIB_SUB_REG: c.op = OP_SUB_ACC_FROM_REG;
          NIB_DEC: c.op = OP_DEC_REG;
          NIB_OR_REG: c.op = OP_OR_REG_ACC;
          NIB_AND_REG: c.op = OP_AND_REG_ACC;
          NIB_XOR_REG: c.op = OP_XOR_REG_ACC;
          NIB_ADD_REG: c.op = OP_ADD_REG_ACC;
          NIB_MOVE_REG: c.op = OP_MOVE_REG;
          NIB_COMPL: c.op = OP_COMPL_REG;
          NIB_INC: c.op = OP_INC_REG;
          NIB_DEC_SKIP: c.op = OP_DEC_SKIP_ZERO;
          NIB_ROT_RIGHT: c.op = OP_ROTATE_RIGHT_CARRY;
          NIB_ROT_LEFT: c.op = OP_ROTATE_LEFT_CARRY;
          NIB_SWAP: c.op = OP_SWAP_NIBBLES;
          default: c.op = OP_INC_SKIP_ZERO;
        endcase
      end
      GRP_BIT:
      begin
        case (w[11:10])
          2'h0: c.op = OP_CLEAR_BIT;
          2'h1: c.op = OP_SET_BIT;
          2'h2: c.op = OP_SKIP_BIT_CLEAR;
          default: c.op = OP_SKIP_BIT_SET;
        endcase
        c.dest_file = (w[11:10] == 2'h0) || (w[11:10] == 2'h1);
      end
      GRP_JUMP: c.op = w[11] ? OP_DIRECT_JUMP : OP_CALL; // 11-bit target in literal
      default:
      begin
        c.literal = {3'h0, w[7:0]}; // 8-bit literal
        if (w[11:10] == 2'h0)
          c.op = OP_MOVE_LIT;
        else if (w[11:10] == 2'h1)
          c.op = OP_RETURN_LOAD_LIT;
        else if (nib == NIB_OR_LIT)
          c.op = OP_OR_LIT_ACC;
        else if (nib == NIB_AND_LIT)
          c.op = OP_AND_LIT_ACC;
        else if (nib == NIB_XOR_LIT)
          c.op = OP_XOR_LIT_ACC;
        else if (w[11:9] == 3'h6)
          c.op = OP_SUB_ACC_FROM_LIT;
        else if (w[11:9] == 3'h7)
          c.op = OP_ADD_LIT_ACC;
        else
          c.op = OP_UNDEF;
      end
    endcase
    // Only ops that store a result keep a destination
    case (c.op)
      OP_MOVE_ACC_REG, OP_CLEAR_REG: c.dest_file = 1'b1;
      OP_SUB_ACC_FROM_REG, OP_DEC_REG, OP_OR_REG_ACC, OP_AND_REG_ACC, OP_XOR_REG_ACC,
      OP_ADD_REG_ACC, OP_MOVE_REG, OP_COMPL_REG, OP_INC_REG, OP_DEC_SKIP_ZERO,
      OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY, OP_SWAP_NIBBLES, OP_INC_SKIP_ZERO,
      OP_CLEAR_BIT, OP_SET_BIT: c.dest_file = c.dest_file;
      default: c.dest_file = 1'b0;
    endcase
    // Status flag updates
    case (c.op)
      OP_ADD_REG_ACC, OP_SUB_ACC_FROM_REG, OP_SUB_ACC_FROM_LIT, OP_ADD_LIT_ACC:
      begin
        c.upd_carry = 1'b1;
        c.upd_digit_carry = 1'b1;
        c.upd_zero = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: c.upd_carry = 1'b1;
      OP_OR_REG_ACC, OP_XOR_REG_ACC, OP_AND_REG_ACC, OP_OR_LIT_ACC, OP_AND_LIT_ACC,
      OP_XOR_LIT_ACC, OP_CLEAR_REG, OP_CLEAR_ACC, OP_COMPL_REG, OP_DEC_REG, OP_INC_REG,
      OP_MOVE_REG: c.upd_zero = 1'b1;
      OP_STANDBY, OP_CLEAR_WATCHDOG: c.upd_wdog_flags = 1'b1;
      default: c.upd_zero = 1'b0; // Skips, bit ops, accumulator-to-file and literal moves, swap: no flags
    endcase
    // Program counter changes always cost a second cycle
    c.pc_change = (c.op == OP_CALL) || (c.op == OP_DIRECT_JUMP) || (c.op == OP_RETURN) ||
                  (c.op == OP_RETURN_INT) || (c.op == OP_RETURN_LOAD_LIT);
    c.cond_skip = (c.op == OP_DEC_SKIP_ZERO) || (c.op == OP_INC_SKIP_ZERO) ||
                  (c.op == OP_SKIP_BIT_CLEAR) || (c.op == OP_SKIP_BIT_SET);
    // Port rewrites take the pin levels; plain stores do not read the file
    is_port = (c.file_addr == PORT_LO_ADDR) || (c.file_addr == PORT_HI_ADDR);
    c.from_pins = is_port && c.dest_file && (c.op != OP_MOVE_ACC_REG) && (c.op != OP_CLEAR_REG);
    c.clr_prescaler = psc_timer && c.dest_file && (c.file_addr == TIMER_ADDR);
    if (c.op == OP_UNDEF)
      c = FID_CTRL_NOP;
    return c;
  endfunction

  // ********************************
  // Skip and flush sequencing
  // ********************************
  // A true test is sampled at the end of the executing cycle, when the datapath result is stable
  always_comb
  begin
    need_flush = 1'b0;
    if (state_q == ST_EXEC)
    begin
      case (ctrl_q.op)
        OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: need_flush = RESULT_ZERO_IN;
        OP_SKIP_BIT_CLEAR: need_flush = !TEST_BIT_IN;
        OP_SKIP_BIT_SET: need_flush = TEST_BIT_IN;
        default: need_flush = ctrl_q.pc_change;
      endcase
    end
  end

  // State moves only on cycle boundaries of four phases
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      state_q <= ST_EXEC;
    else if (cycle_end)
    begin
      case (state_q)
        ST_EXEC: state_q <= need_flush ? ST_FLUSH : ST_EXEC;
        ST_FLUSH: state_q <= ST_EXEC;
        default: state_q <= ST_EXEC;
      endcase
    end
  end

  // Prefetched word is discarded when a flush is due
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      ctrl_q <= FID_CTRL_NOP;
    else if (cycle_end)
      ctrl_q <= need_flush ? FID_CTRL_NOP : decode(INSTR_IN, PRESCALE_TO_TIMER_IN);
  end

  assign CTRL_OUT = ctrl_q;
  assign CYCLE_END_OUT = cycle_end;
  assign FLUSH_OUT = (state_q == ST_FLUSH);

  // ********************************
  // Assertions
  // ********************************
  sequence s_skip_due;
    cycle_end && state_q == ST_EXEC && need_flush;
  endsequence
  sequence s_nop_cycle;
    (state_q == ST_FLUSH && ctrl_q.op == OP_NOP)[*4];
  endsequence

  AST_LOGIC_ZERO_ONLY: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op inside {OP_OR_REG_ACC, OP_XOR_REG_ACC, OP_AND_REG_ACC} |->
    ctrl_q.upd_zero && !ctrl_q.upd_carry && !ctrl_q.upd_digit_carry && !ctrl_q.upd_wdog_flags)
    else $error("register logic op flags wrong");
  AST_ARITH_FLAGS: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op inside {OP_ADD_REG_ACC, OP_SUB_ACC_FROM_REG, OP_SUB_ACC_FROM_LIT} |->
    ctrl_q.upd_carry && ctrl_q.upd_digit_carry && ctrl_q.upd_zero)
    else $error("arithmetic flags wrong");
  AST_ROTATE_CARRY: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op inside {OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY} |->
    ctrl_q.upd_carry && !ctrl_q.upd_zero && !ctrl_q.upd_digit_carry)
    else $error("rotate flags wrong");
  AST_COUNT_SKIP: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end && state_q == ST_EXEC && RESULT_ZERO_IN &&
    ctrl_q.op inside {OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO} |=> s_nop_cycle ##1 state_q == ST_EXEC)
    else $error("count skip did not flush one cycle");
  AST_COUNT_NO_FLAGS: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op inside {OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO} |->
    !(ctrl_q.upd_zero || ctrl_q.upd_carry || ctrl_q.upd_digit_carry) && ctrl_q.cond_skip)
    else $error("count skip flags wrong");
  AST_LIT_LOGIC: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op inside {OP_OR_LIT_ACC, OP_AND_LIT_ACC, OP_XOR_LIT_ACC} |->
    ctrl_q.upd_zero && !ctrl_q.upd_carry && ctrl_q.literal[10:8] == 3'h0)
    else $error("literal logic decode wrong");
  AST_RETURN_LIT: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end && state_q == ST_EXEC && ctrl_q.op == OP_RETURN_LOAD_LIT |=> s_nop_cycle)
    else $error("return with literal not two cycles");
  AST_BIT_SKIP: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end && state_q == ST_EXEC && ((ctrl_q.op == OP_SKIP_BIT_CLEAR && !TEST_BIT_IN) ||
    (ctrl_q.op == OP_SKIP_BIT_SET && TEST_BIT_IN)) |=> FLUSH_OUT)
    else $error("bit test did not skip");
  AST_STANDBY: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end && state_q == ST_EXEC && ctrl_q.op == OP_STANDBY |->
    ctrl_q.upd_wdog_flags && !need_flush)
    else $error("standby flags or length wrong");
  AST_PORT_PINS: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op == OP_MOVE_REG && ctrl_q.dest_file && ctrl_q.file_addr == PORT_LO_ADDR |->
    ctrl_q.from_pins)
    else $error("port rewrite not from pins");
  AST_PRESCALE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.clr_prescaler |-> ctrl_q.dest_file && ctrl_q.file_addr == TIMER_ADDR)
    else $error("prescaler clear without timer write");
  AST_FLUSH_NOP: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_skip_due |=> s_nop_cycle)
    else $error("second cycle not a no-operation");
  AST_JUMP_TWO: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end && state_q == ST_EXEC && ctrl_q.op inside {OP_CALL, OP_DIRECT_JUMP} |=>
    s_nop_cycle ##1 state_q == ST_EXEC)
    else $error("jump not two cycles");
  AST_DEST_ACC: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ctrl_q.op inside {OP_OR_LIT_ACC, OP_MOVE_LIT, OP_SKIP_BIT_SET} |-> !ctrl_q.dest_file)
    else $error("non-storing op selects file");
  AST_CYCLE_LEN: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end |=> (!cycle_end)[*3] ##1 cycle_end)
    else $error("instruction cycle not four periods");
  AST_BIT_WRITE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cycle_end && state_q == ST_EXEC && ctrl_q.op inside {OP_CLEAR_BIT, OP_SET_BIT} |->
    !need_flush && !ctrl_q.upd_zero && ctrl_q.dest_file)
    else $error("bit write wrong");

endmodule
`default_nettype wire

// file: verif/fid_prog_mem.sv
// Program memory stand-in that presents the bench's chosen word to the decoder
`timescale 1ns/100ps
`default_nettype none
module fid_prog_mem
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Word chosen by the bench
  input wire logic [fid_pkg::FID_WORD_W-1:0] word_in,
  // Word fetched for the decoder
  output logic [fid_pkg::FID_WORD_W-1:0] instr_out
);
  import fid_pkg::*;

  // ************************************
  // Fetch register
  // ************************************
  // Output moves just after the edge, so the decoder's sampling edge never races it
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      instr_out <= '0;
    else
      instr_out <= #1 word_in;
  end
endmodule
`default_nettype wire

// file: verif/fid_decoder_bench.sv
// Self-checking bench for the 14-bit instruction decoder
`timescale 1ns/100ps
`default_nettype none
module fid_decoder_bench;
  import fid_pkg::*;

  // ************************************
  // Signals and case tables
  // ************************************
  // Flag byte order: carry, digit carry, zero, watchdog, dest, pins, prescaler, pc change
  typedef struct packed {
    logic [13:0] w;
    fid_op_t op;
    logic [7:0] fl;
    logic [7:0] m;
  } fid_row_t;
  logic CLK_IN = 1'b0;
  logic RSTN_IN = 1'b0;
  logic [13:0] word_d = '0;
  logic [13:0] INSTR_IN;
  logic RESULT_ZERO_IN = 1'b0;
  logic TEST_BIT_IN = 1'b0;
  logic PRESCALE_TO_TIMER_IN = 1'b0;
  fid_ctrl_t CTRL_OUT;
  logic [1:0] PHASE_OUT;
  logic CYCLE_END_OUT;
  logic FLUSH_OUT;
  int errors = 0;
  int checks_done = 0;
  fid_op_t prev;
  fid_row_t rows[32] = '{
    '{14'h0485, OP_OR_REG_ACC, 8'h2c, 8'hff}, '{14'h067f, OP_XOR_REG_ACC, 8'h20, 8'hff},
    '{14'h0581, OP_AND_REG_ACC, 8'h2a, 8'hff}, '{14'h0710, OP_ADD_REG_ACC, 8'he0, 8'hff},
    '{14'h02a0, OP_SUB_ACC_FROM_REG, 8'he8, 8'hff}, '{14'h3c55, OP_SUB_ACC_FROM_LIT, 8'he0, 8'hff},
    '{14'h3daa, OP_SUB_ACC_FROM_LIT, 8'he0, 8'hff}, '{14'h0d86, OP_ROTATE_LEFT_CARRY, 8'h8c, 8'hff},
    '{14'h0c30, OP_ROTATE_RIGHT_CARRY, 8'h80, 8'hff}, '{14'h0bc0, OP_DEC_SKIP_ZERO, 8'h08, 8'hff},
    '{14'h0f7f, OP_INC_SKIP_ZERO, 8'h00, 8'hff}, '{14'h3812, OP_OR_LIT_ACC, 8'h20, 8'hff},
    '{14'h3934, OP_AND_LIT_ACC, 8'h20, 8'hff}, '{14'h3a56, OP_XOR_LIT_ACC, 8'h20, 8'hff},
    '{14'h0063, OP_STANDBY, 8'h10, 8'hff}, '{14'h0064, OP_CLEAR_WATCHDOG, 8'h10, 8'hff},
    '{14'h1385, OP_CLEAR_BIT, 8'h04, 8'hf7}, '{14'h1401, OP_SET_BIT, 8'h02, 8'hf7},
    '{14'h1805, OP_SKIP_BIT_CLEAR, 8'h00, 8'hf3}, '{14'h1c05, OP_SKIP_BIT_SET, 8'h00, 8'hf3},
    '{14'h0181, OP_CLEAR_REG, 8'h2a, 8'hff}, '{14'h0081, OP_MOVE_ACC_REG, 8'h0a, 8'hff},
    '{14'h0885, OP_MOVE_REG, 8'h2c, 8'hff}, '{14'h0910, OP_COMPL_REG, 8'h20, 8'hff},
    '{14'h0a10, OP_INC_REG, 8'h20, 8'hff}, '{14'h0310, OP_DEC_REG, 8'h20, 8'hff},
    '{14'h0e10, OP_SWAP_NIBBLES, 8'h00, 8'hff}, '{14'h0103, OP_CLEAR_ACC, 8'h20, 8'hff},
    '{14'h0000, OP_NOP, 8'h00, 8'hff}, '{14'h3e10, OP_ADD_LIT_ACC, 8'he0, 8'hff},
    '{14'h3001, OP_MOVE_LIT, 8'h00, 8'hff}, '{14'h3b00, OP_NOP, 8'h00, 8'hff}};
  logic [13:0] br_w[5] = '{14'h2123, 14'h2fff, 14'h3477, 14'h0008, 14'h0009};
  fid_op_t br_op[5] = '{OP_CALL, OP_DIRECT_JUMP, OP_RETURN_LOAD_LIT, OP_RETURN, OP_RETURN_INT};
  logic [13:0] sk_w[4] = '{14'h0bc0, 14'h0f7f, 14'h1805, 14'h1c05};
  logic sk_b[4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  // Free-running oscillator clock
  always #5 CLK_IN = ~CLK_IN;

  fid_prog_mem u_mem (.clk_in(CLK_IN), .rstn_in(RSTN_IN), .word_in(word_d), .instr_out(INSTR_IN));
  fid_decoder u_dut (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .INSTR_IN(INSTR_IN), .RESULT_ZERO_IN(RESULT_ZERO_IN),
    .TEST_BIT_IN(TEST_BIT_IN), .PRESCALE_TO_TIMER_IN(PRESCALE_TO_TIMER_IN), .CTRL_OUT(CTRL_OUT),
    .PHASE_OUT(PHASE_OUT), .CYCLE_END_OUT(CYCLE_END_OUT), .FLUSH_OUT(FLUSH_OUT));

  // ************************************
  // Shared tasks
  // ************************************
  // Compare one seen value against its expectation
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Report counts and end the run
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Feedback applies to the op executing now; the word is taken at the coming cycle end
  task automatic issue(input logic [13:0] w, input logic fb, input logic pre);
    word_d = w;
    RESULT_ZERO_IN = fb;
    TEST_BIT_IN = fb;
    PRESCALE_TO_TIMER_IN = pre;
    do @(negedge CLK_IN); while (CYCLE_END_OUT !== 1'b1);
    @(posedge CLK_IN);
    #1;
  endtask

  // Operand fields follow the group layout
  task automatic chk_fields(input logic [13:0] w);
    if (w[13:12] == GRP_LIT)
      check(CTRL_OUT.literal, {3'h0, w[7:0]});
    else if (w[13:12] == GRP_JUMP)
      check(CTRL_OUT.literal, w[10:0]);
    else
      check(CTRL_OUT.file_addr, w[6:0]);
    if (w[13:12] == GRP_BIT)
      check(CTRL_OUT.bit_idx, w[9:7]);
  endtask

  // Watchdog: the whole sequence needs well under this span
  initial
  begin
    #100000;
    errors++;
    print_verdict();
  end

  // ************************************
  // Main sequence
  // ************************************
  initial
  begin
    @(posedge CLK_IN);
    #1;
    check(CTRL_OUT, FID_CTRL_NOP);
    check({FLUSH_OUT, CYCLE_END_OUT, PHASE_OUT}, 4'h0);
    @(posedge CLK_IN);
    #1;
    RSTN_IN = 1'b1;
    prev = OP_NOP;
    // Table of ordinary decodes; a bit-clear test gets a set bit next so it never skips
    foreach (rows[i])
    begin
      issue(rows[i].w, prev == OP_SKIP_BIT_CLEAR, 1'b1);
      check(CTRL_OUT.op, rows[i].op);
      if (rows[i].op == OP_NOP)
        check(CTRL_OUT, FID_CTRL_NOP);
      check({CTRL_OUT.upd_carry, CTRL_OUT.upd_digit_carry, CTRL_OUT.upd_zero, CTRL_OUT.upd_wdog_flags,
        CTRL_OUT.dest_file, CTRL_OUT.from_pins, CTRL_OUT.clr_prescaler, CTRL_OUT.pc_change} & rows[i].m,
        rows[i].fl & rows[i].m);
      if (!(rows[i].op inside {OP_NOP, OP_CLEAR_ACC, OP_STANDBY, OP_CLEAR_WATCHDOG}))
        chk_fields(rows[i].w);
      prev = rows[i].op;
    end
    // Timer write without prescaler assignment, then four clocks of one cycle
    issue(14'h0581, 1'b0, 1'b0);
    check(CTRL_OUT.clr_prescaler, 1'b0);
    check(CTRL_OUT.cond_skip, 1'b0);
    for (int j = 0; j < 4; j++)
    begin
      check(PHASE_OUT, j[1:0]);
      check(CYCLE_END_OUT, j == 3);
      check(CTRL_OUT.op, OP_AND_REG_ACC);
      @(posedge CLK_IN);
      #1;
    end
    // Branches: the following word is flushed, the one after runs
    foreach (br_w[i])
    begin
      issue(br_w[i], 1'b0, 1'b0);
      check(CTRL_OUT.op, br_op[i]);
      check(CTRL_OUT.pc_change, 1'b1);
      if (i < 3)
        chk_fields(br_w[i]);
      issue(14'h0710, 1'b0, 1'b0);
      check({CTRL_OUT.op, FLUSH_OUT}, {OP_NOP, 1'b1});
      issue(14'h0710, 1'b0, 1'b0);
      check({CTRL_OUT.op, FLUSH_OUT}, {OP_ADD_REG_ACC, 1'b0});
    end
    // Conditional skips, both outcomes of each test
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 2; k++)
      begin
        issue(sk_w[i], 1'b0, 1'b0);
        check(CTRL_OUT.cond_skip, 1'b1);
        issue(14'h0710, k[0], 1'b0);
        check(FLUSH_OUT, k[0] == sk_b[i]);
        check(CTRL_OUT.op, (k[0] == sk_b[i]) ? OP_NOP : OP_ADD_REG_ACC);
      end
    // Second reset in mid-run, then decoding resumes
    RSTN_IN = 1'b0;
    #1;
    check(CTRL_OUT, FID_CTRL_NOP);
    check({FLUSH_OUT, CYCLE_END_OUT, PHASE_OUT}, 4'h0);
    repeat (2) @(posedge CLK_IN);
    #1;
    RSTN_IN = 1'b1;
    issue(14'h0485, 1'b0, 1'b0);
    check(CTRL_OUT.op, OP_OR_REG_ACC);
    print_verdict();
  end
endmodule
`default_nettype wire
